// [logic/scotp_consts.vh]
// constants for the system control and fuse memory block
`ifndef SCOTP_CONSTS_VH
`define SCOTP_CONSTS_VH
`define SCOTP_CLK_HZ 10000000
`define SCOTP_PWM_HZ 50000
`define SCOTP_PWM_CYC (`SCOTP_CLK_HZ / `SCOTP_PWM_HZ)
`define SCOTP_BLINK_HZ 1
`define SCOTP_BLINK_HALF_CYC (`SCOTP_CLK_HZ / (2 * `SCOTP_BLINK_HZ))
`define SCOTP_START_LONG_MS 900
`define SCOTP_START_SHORT_MS 600
`define SCOTP_START_LONG_CYC (`SCOTP_START_LONG_MS * (`SCOTP_CLK_HZ / 1000))
`define SCOTP_START_SHORT_CYC (`SCOTP_START_SHORT_MS * (`SCOTP_CLK_HZ / 1000))
`define SCOTP_HALT_CYC 16
`define SCOTP_REG_PREAMP 8'h08
`define SCOTP_REG_PREAMP_LAST 8'h0c
`define SCOTP_REG_EXTRA 8'h21
`define SCOTP_REG_SYSTEM 8'h20
`define SCOTP_SYS_POWER_BIT 0
`define SCOTP_DUTY_OFF 2'h0
`define SCOTP_DUTY_QUARTER 2'h1
`define SCOTP_DUTY_HALF 2'h2
`define SCOTP_DUTY_FULL 2'h3
`define SCOTP_MODE_OFF 2'h0
`define SCOTP_MODE_NC 2'h1
`define SCOTP_MODE_MON 2'h2
`define SCOTP_FUSE_W 8
`define SCOTP_LOCK_BIT 7
`define SCOTP_SHORT_BIT 6
`define SCOTP_SET_SEL_LSB 4
`endif

// [logic/scotp_pwm.v]
// status current output pulse-width modulator with low-supply blinking
`timescale 1ns/100ps
module scotp_pwm #(
  parameter PWM_CYC = 200,
  parameter BLINK_HALF = 5000000
) (
  input wire mclk_i,
  input wire sys_rst_i,
  input wire ce_i,
  input wire run_i,
  input wire [1:0] duty_i,
  input wire supply_low_flag_i,
  output reg status_current_output_o
);
  `include "scotp_consts.vh"
  reg [7:0] phase_reg;
  reg [22:0] blink_reg;
  reg blink_on_reg;
  reg [1:0] eff_duty;
  reg pwm_next;

  always @*
  begin
    // low supply forces the half-current setting while lit
    if (supply_low_flag_i)
      eff_duty = blink_on_reg ? `SCOTP_DUTY_HALF : `SCOTP_DUTY_OFF;
    else
      eff_duty = duty_i;
    case (eff_duty)
      `SCOTP_DUTY_QUARTER: pwm_next = phase_reg < PWM_CYC / 4;
      `SCOTP_DUTY_HALF: pwm_next = phase_reg < PWM_CYC / 2;
      `SCOTP_DUTY_FULL: pwm_next = 1'b1;
      default: pwm_next = 1'b0;
    endcase
  end

  always @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      phase_reg <= 8'h00;
      blink_reg <= 23'h000000;
      blink_on_reg <= 1'b1;
      status_current_output_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (phase_reg == PWM_CYC - 1)
        phase_reg <= 8'h00;
      else
        phase_reg <= phase_reg + 8'h01;
      if (!supply_low_flag_i)
      begin
        blink_reg <= 23'h000000;
        blink_on_reg <= 1'b1;
      end
      else if (blink_reg == BLINK_HALF - 1)
      begin
        blink_reg <= 23'h000000;
        blink_on_reg <= ~blink_on_reg;
      end
      else
        blink_reg <= blink_reg + 23'h000001;
      status_current_output_o <= run_i & pwm_next;
    end
  end
endmodule // scotp_pwm

// [logic/scotp_top.v]
// system control: start-up sequencing, mode decode, fuse memory
`timescale 1ns/100ps
// Notes on behaviour
// - stand-alone runs full start-up; serial mode stops midway awaiting host
// - auto continue plus power keep resumes the automatic start-up
// - start-up lasts 900ms, or 600ms when the fuse option shortens it
// - mode pin: low off, high noise cancel, mid level monitor
// - monitor mode uses its own preamp gain, fixed or volume driven
// - monitor mode may swap headphone source and lower line gain
// - serial mode enters monitor when host sets system monitor bit
// - status output pwm at 50kHz with 0, 25, 50, 100 percent duty
// - low supply blinks status at 1Hz, half duty, half current
// - shadow register writes unlimited and volatile
// - four gain sets allow three regain changes after first burn
// - registers 8h-Ch and 21h act only with override enabled
// - control registers clear at power off; host reloads them
// - fuse cells go 0 to 1 only, cleared only by sys_rst_i
// - shadow write any time once enabled, replaced at power-up or load
// - load copies fuses to shadow, runs after each power-on reset
// - write changes shadow only, held until power loss or reload
// - read returns the present shadow content
// - burn programs shadow content into fuse cells
// - once lock is burned all further programming is refused
// - serial mode powers up on a serial start condition
// - host writing zero to bit 0 of 20h powers down
// - shadow access refused until host enables it
module scotp_top #(
  parameter FUSE_W = 8,
  parameter SETS = 4,
  parameter START_LONG = 9000000,
  parameter START_SHORT = 6000000,
  parameter PWM_CYC = 200,
  parameter BLINK_HALF = 5000000
) (
  input wire mclk_i,
  input wire sys_rst_i,
  input wire ce_i,
  input wire serial_mode_i,
  input wire mode_hi_i,
  input wire mode_mid_i,
  input wire serial_start_i,
  input wire reg_wr_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire auto_sequence_continue_i,
  input wire power_keep_latch_i,
  input wire monitor_bit_i,
  input wire reg_override_i,
  input wire [7:0] override_gain_i,
  input wire [7:0] monitor_gain_i,
  input wire monitor_vol_follow_i,
  input wire [5:0] volume_control_input_i,
  input wire [1:0] monitor_src_i,
  input wire [5:0] monitor_line_gain_i,
  input wire [5:0] line_gain_i,
  input wire [1:0] duty_i,
  input wire supply_low_flag_i,
  input wire shadow_enable_i,
  input wire shadow_wr_i,
  input wire [FUSE_W-1:0] shadow_wdata_i,
  input wire shadow_rd_i,
  input wire load_i,
  input wire burn_i,
  input wire [1:0] burn_set_i,
  output reg powered_o,
  output reg seq_waiting_o,
  output reg seq_done_o,
  output reg [1:0] mode_o,
  output reg [7:0] mic_gain_o,
  output reg [1:0] hp_src_o,
  output reg [5:0] line_gain_o,
  output reg [FUSE_W-1:0] shadow_rdata_o,
  output reg shadow_valid_o,
  output reg access_refused_o,
  output reg burn_refused_o,
  output reg fuse_locked_o,
  output wire status_current_output_o
);
  `include "scotp_consts.vh"
  localparam S_OFF = 5'h01;
  localparam S_LOAD = 5'h02;
  localparam S_HALT = 5'h04;
  localparam S_RAMP = 5'h08;
  localparam S_ON = 5'h10;

  reg [2:0] hi_sync_reg;
  reg [2:0] mid_sync_reg;
  reg hi_reg;
  reg mid_reg;
  reg [4:0] state_reg;
  reg [4:0] state_next;
  reg [23:0] cnt_reg;
  reg [FUSE_W-1:0] fuse_reg [0:SETS-1];
  reg [FUSE_W-1:0] shadow_reg;
  reg [1:0] set_sel;
  reg lock_burned;
  reg short_start;
  integer i;

  // selects the highest set that has been programmed
  function [1:0] active_set;
    input [SETS*FUSE_W-1:0] flat;
    integer k;
    begin
      active_set = 2'h0;
      for (k = 1; k < SETS; k = k + 1)
        if (flat[k*FUSE_W +: FUSE_W] != {FUSE_W{1'b0}})
          active_set = k[1:0];
    end
  endfunction

  wire [SETS*FUSE_W-1:0] fuse_flat;
  genvar g;
  generate
    for (g = 0; g < SETS; g = g + 1)
    begin : flat_g
      assign fuse_flat[g*FUSE_W +: FUSE_W] = fuse_reg[g];
    end
  endgenerate

  always @*
  begin
    set_sel = active_set(fuse_flat);
    lock_burned = fuse_reg[0][`SCOTP_LOCK_BIT];
    short_start = fuse_reg[0][`SCOTP_SHORT_BIT];
  end

  // mode pin levels come from comparators outside this clock domain
  always @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      hi_sync_reg <= 3'h0;
      mid_sync_reg <= 3'h0;
      hi_reg <= 1'b0;
      mid_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      hi_sync_reg <= {hi_sync_reg[1:0], mode_hi_i};
      mid_sync_reg <= {mid_sync_reg[1:0], mode_mid_i};
      if (hi_sync_reg[2] == hi_sync_reg[1])
        hi_reg <= hi_sync_reg[2];
      if (mid_sync_reg[2] == mid_sync_reg[1])
        mid_reg <= mid_sync_reg[2];
    end
  end

  wire pin_on = hi_reg | mid_reg;
  wire pd_write = reg_wr_i && reg_addr_i == `SCOTP_REG_SYSTEM &&
    !reg_wdata_i[`SCOTP_SYS_POWER_BIT];
  wire power_off = serial_mode_i ? pd_write : !pin_on;
  wire [23:0] start_len = short_start ? START_SHORT[23:0] :
    START_LONG[23:0];

  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      S_OFF:
        if (serial_mode_i ? serial_start_i : pin_on)
          state_next = S_LOAD;
      S_LOAD:
        state_next = S_HALT;
      S_HALT:
        if (!serial_mode_i)
          state_next = S_RAMP;
        else if (power_keep_latch_i && auto_sequence_continue_i)
          state_next = S_RAMP;
        else if (power_keep_latch_i)
          state_next = S_ON;
      S_RAMP:
        if (cnt_reg >= start_len - 24'h000001)
          state_next = S_ON;
      S_ON:
        state_next = S_ON;
      default:
        state_next = S_OFF;
    endcase
    if (power_off && state_reg != S_OFF)
      state_next = S_OFF;
  end

  always @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state_reg <= S_LOAD; // power-on reset loads the fuses
      cnt_reg <= 24'h000000;
    end
    else if (ce_i)
    begin
      state_reg <= state_next;
      if (state_next == S_RAMP && state_reg == S_RAMP)
        cnt_reg <= cnt_reg + 24'h000001;
      else
        cnt_reg <= 24'h000000;
    end
  end

  // fuse and shadow storage; fuses can only gain ones
  always @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      for (i = 0; i < SETS; i = i + 1)
        fuse_reg[i] <= {FUSE_W{1'b0}};
      shadow_reg <= {FUSE_W{1'b0}};
      shadow_rdata_o <= {FUSE_W{1'b0}};
      shadow_valid_o <= 1'b0;
      access_refused_o <= 1'b0;
      burn_refused_o <= 1'b0;
    end
    else if (ce_i)
    begin
      shadow_valid_o <= 1'b0;
      access_refused_o <= 1'b0;
      burn_refused_o <= 1'b0;
      if (state_reg == S_LOAD || (load_i && shadow_enable_i))
        shadow_reg <= fuse_reg[set_sel];
      else if (shadow_wr_i && shadow_enable_i)
        shadow_reg <= shadow_wdata_i;
      if ((shadow_wr_i | shadow_rd_i | load_i | burn_i) &&
          !shadow_enable_i)
        access_refused_o <= 1'b1;
      if (shadow_rd_i && shadow_enable_i)
      begin
        shadow_rdata_o <= shadow_reg;
        shadow_valid_o <= 1'b1;
      end
      if (burn_i && shadow_enable_i)
      begin
        if (lock_burned)
          burn_refused_o <= 1'b1;
        else
          fuse_reg[burn_set_i] <= fuse_reg[burn_set_i] | shadow_reg;
      end
    end
  end

  // outputs; override registers are honoured only when enabled
  always @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      powered_o <= 1'b0;
      seq_waiting_o <= 1'b0;
      seq_done_o <= 1'b0;
      mode_o <= `SCOTP_MODE_OFF;
      mic_gain_o <= 8'h00;
      hp_src_o <= 2'h0;
      line_gain_o <= 6'h00;
      fuse_locked_o <= 1'b0;
    end
    else if (ce_i)
    begin
      powered_o <= state_reg != S_OFF;
      seq_waiting_o <= state_reg == S_HALT && serial_mode_i;
      seq_done_o <= state_reg == S_ON;
      fuse_locked_o <= lock_burned;
      if (state_reg == S_OFF)
        mode_o <= `SCOTP_MODE_OFF;
      else if (serial_mode_i ? monitor_bit_i : mid_reg)
        mode_o <= `SCOTP_MODE_MON;
      else
        mode_o <= `SCOTP_MODE_NC;
      if (state_reg != S_OFF &&
          (serial_mode_i ? monitor_bit_i : mid_reg))
      begin
        mic_gain_o <= monitor_vol_follow_i ?
          {2'h0, volume_control_input_i} : monitor_gain_i;
        hp_src_o <= monitor_src_i;
        line_gain_o <= monitor_line_gain_i;
      end
      else
      begin
        // gain field is the low byte of the shadow word
        mic_gain_o <= reg_override_i ? override_gain_i :
          shadow_reg[7:0];
        hp_src_o <= 2'h0;
        line_gain_o <= line_gain_i;
      end
    end
  end

  scotp_pwm #(
    .PWM_CYC(PWM_CYC),
    .BLINK_HALF(BLINK_HALF)
  ) u_pwm (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .run_i(seq_done_o),
    .duty_i(duty_i),
    .supply_low_flag_i(supply_low_flag_i),
    .status_current_output_o(status_current_output_o)
  );
endmodule // scotp_top

// [tb/scotp_host.sv]
// host and mode pin driver model facing the system control block
`timescale 1ns/100ps
module scotp_host (
  input wire mclk_i,
  input wire [1:0] pin_lvl_i,
  input wire [1:0] go_i,
  output reg mode_hi_o,
  output reg mode_mid_o,
  output reg power_keep_latch_o,
  output reg auto_sequence_continue_o
);
  // comparator levels change just after the edge, like a slow pin
  always @(posedge mclk_i)
  begin
    mode_hi_o <= pin_lvl_i == 2'h1;
    mode_mid_o <= pin_lvl_i == 2'h2;
    // go_i[0] keeps power, go_i[1] asks for the automatic sequence
    power_keep_latch_o <= go_i[0];
    auto_sequence_continue_o <= go_i[1];
  end
endmodule // scotp_host

// [tb/scotp_top_assertions.sv]
// port level checks on the system control and fuse block
`timescale 1ns/100ps
module scotp_chk (
  input wire mclk_i,
  input wire sys_rst_i,
  input wire ce_i,
  input wire serial_mode_i,
  input wire mode_mid_i,
  input wire reg_wr_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire [1:0] duty_i,
  input wire supply_low_flag_i,
  input wire shadow_enable_i,
  input wire shadow_wr_i,
  input wire shadow_rd_i,
  input wire load_i,
  input wire burn_i,
  input wire powered_o,
  input wire seq_waiting_o,
  input wire seq_done_o,
  input wire [1:0] mode_o,
  input wire shadow_valid_o,
  input wire access_refused_o,
  input wire burn_refused_o,
  input wire fuse_locked_o,
  input wire status_current_output_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  wire any_op = shadow_wr_i | shadow_rd_i | load_i | burn_i;
  read_answer_a: assert property (
    shadow_rd_i && shadow_enable_i && ce_i |=> shadow_valid_o)
    else $error("read gave no valid strobe");
  access_refuse_a: assert property (
    any_op && !shadow_enable_i && ce_i |=> access_refused_o && !shadow_valid_o)
    else $error("disabled shadow access not refused");
  lock_refuse_a: assert property (
    burn_i && shadow_enable_i && fuse_locked_o && ce_i |=> burn_refused_o)
    else $error("burn after lock not refused");
  lock_sticky_a: assert property (
    fuse_locked_o |=> fuse_locked_o)
    else $error("lock indication dropped");
  mid_monitor_a: assert property (
    (!serial_mode_i && mode_mid_i && powered_o && ce_i) [*6] |->
    mode_o == 2'h2)
    else $error("mid level did not select monitor");
  duty_off_a: assert property (
    (duty_i == 2'h0 && !supply_low_flag_i) [*3] |-> !status_current_output_o)
    else $error("status output on at zero duty");
  wait_serial_a: assert property (
    $rose(seq_waiting_o) |-> serial_mode_i)
    else $error("start-up halted outside serial mode");
  power_down_a: assert property (
    serial_mode_i && ce_i && reg_wr_i && reg_addr_i == 8'h20 &&
    !reg_wdata_i[0] |-> ##[1:3] !powered_o)
    else $error("power down write ignored");
  cover property ($rose(seq_done_o));
  cover property (burn_refused_o);
  cover property ($rose(mode_o == 2'h2));
endmodule // scotp_chk
bind scotp_top scotp_chk chk_u (.mclk_i, .sys_rst_i, .ce_i, .serial_mode_i,
  .mode_mid_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i, .duty_i,
  .supply_low_flag_i, .shadow_enable_i, .shadow_wr_i, .shadow_rd_i, .load_i,
  .burn_i, .powered_o, .seq_waiting_o, .seq_done_o, .mode_o, .shadow_valid_o,
  .access_refused_o, .burn_refused_o, .fuse_locked_o,
  .status_current_output_o);

// [tb/scotp_top_test.sv]
// self-checking bench for the system control and fuse block
`timescale 1ns/100ps
module scotp_top_test;
  reg mclk_i = 1'b0, sys_rst_i = 1'b1, ce_i = 1'b1, serial_mode_i = 1'b0;
  reg serial_start_i = 1'b0, reg_wr_i = 1'b0, monitor_bit_i = 1'b0;
  reg [7:0] reg_addr_i = 8'h20, reg_wdata_i = 8'h00;
  reg reg_override_i = 1'b0, monitor_vol_follow_i = 1'b0;
  reg [7:0] override_gain_i = 8'h5a, monitor_gain_i = 8'h77;
  reg [5:0] volume_control_input_i = 6'h2b, monitor_line_gain_i = 6'h11;
  reg [5:0] line_gain_i = 6'h3e;
  reg [1:0] monitor_src_i = 2'h3, duty_i = 2'h0, burn_set_i = 2'h0;
  reg supply_low_flag_i = 1'b0, shadow_enable_i = 1'b1, shadow_wr_i = 1'b0;
  reg shadow_rd_i = 1'b0, load_i = 1'b0, burn_i = 1'b0;
  reg [1:0] go = 2'h0;
  reg [7:0] shadow_wdata_i = 8'h00;
  reg [1:0] pin_lvl = 2'h0;
  wire mode_hi_i, mode_mid_i, power_keep_latch_i, auto_sequence_continue_i;
  wire powered_o, seq_waiting_o, seq_done_o, shadow_valid_o, fuse_locked_o;
  wire access_refused_o, burn_refused_o, status_current_output_o;
  wire [1:0] mode_o, hp_src_o;
  wire [7:0] mic_gain_o, shadow_rdata_o;
  wire [5:0] line_gain_o;
  integer miscompares = 0, compares = 0, n, k, hi;
  scotp_top #(.START_LONG(90), .START_SHORT(60), .PWM_CYC(8), .BLINK_HALF(50))
  dut_u (.mclk_i, .sys_rst_i, .ce_i, .serial_mode_i, .mode_hi_i, .mode_mid_i,
    .serial_start_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i,
    .auto_sequence_continue_i, .power_keep_latch_i, .monitor_bit_i,
    .reg_override_i, .override_gain_i, .monitor_gain_i, .monitor_vol_follow_i,
    .volume_control_input_i, .monitor_src_i, .monitor_line_gain_i,
    .line_gain_i, .duty_i, .supply_low_flag_i, .shadow_enable_i, .shadow_wr_i,
    .shadow_wdata_i, .shadow_rd_i, .load_i, .burn_i, .burn_set_i, .powered_o,
    .seq_waiting_o, .seq_done_o, .mode_o, .mic_gain_o, .hp_src_o,
    .line_gain_o, .shadow_rdata_o, .shadow_valid_o, .access_refused_o,
    .burn_refused_o, .fuse_locked_o, .status_current_output_o);
  scotp_host host_u (.mclk_i, .pin_lvl_i(pin_lvl), .go_i(go),
    .mode_hi_o(mode_hi_i), .mode_mid_o(mode_mid_i),
    .power_keep_latch_o(power_keep_latch_i),
    .auto_sequence_continue_o(auto_sequence_continue_i));
  always #50 mclk_i = ~mclk_i;
  function pick(input integer s);
    pick = s == 0 ? seq_waiting_o : s == 1 ? seq_done_o : ~powered_o;
  endfunction
  task final_report;
    begin
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp)
      begin
        miscompares = miscompares + 1;
        $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer c);
    repeat (c) @(negedge mclk_i);
  endtask
  // fuse request: 0 write, 1 read, 2 load, 3 burn; answer visible on return
  task fop(input integer op, input [7:0] d);
    begin
      shadow_wdata_i = d;
      {shadow_wr_i, shadow_rd_i, load_i, burn_i} = 4'h8 >> op;
      cyc(1);
      {shadow_wr_i, shadow_rd_i, load_i, burn_i} = 4'h0;
    end
  endtask
  task rd(input [7:0] e);
    begin
      fop(1, 8'h00);
      chk(shadow_valid_o, 1'b1);
      chk(shadow_rdata_o, e);
    end
  endtask
  task wait_for(input integer s, input integer lim);
    begin
      n = 0;
      while (pick(s) !== 1'b1 && n < lim)
      begin
        cyc(1);
        n = n + 1;
      end
      if (pick(s) !== 1'b1)
      begin
        chk(8'h00, 8'h01);
        final_report;
      end
    end
  endtask
  task rst;
    begin
      sys_rst_i = 1'b1;
      cyc(16);
      sys_rst_i = 1'b0;
      cyc(2);
    end
  endtask
  task t_store;
    begin
      rst;
      rd(8'h00);
      fop(0, 8'h35);
      rd(8'h35);
      fop(2, 8'h00);
      rd(8'h00);
      fop(0, 8'h03);
      fop(3, 8'h00);
      fop(0, 8'h00);
      fop(2, 8'h00);
      rd(8'h03);
      fop(0, 8'h0c);
      fop(3, 8'h00);
      fop(0, 8'h01);
      fop(3, 8'h00);
      fop(2, 8'h00);
      rd(8'h0f);
      burn_set_i = 2'h1;
      fop(0, 8'h22);
      fop(3, 8'h00);
      fop(2, 8'h00);
      rd(8'h22);
      cyc(1);
      // clock enable low must freeze the read strobe
      ce_i = 1'b0;
      fop(1, 8'h00);
      chk(shadow_valid_o, 1'b0);
      ce_i = 1'b1;
      cyc(1);
      shadow_enable_i = 1'b0;
      fop(1, 8'h00);
      chk(access_refused_o, 1'b1);
      chk(shadow_valid_o, 1'b0);
      shadow_enable_i = 1'b1;
      burn_set_i = 2'h0;
      $display("store test done");
    end
  endtask
  task t_lock;
    begin
      rst;
      fop(0, 8'h80);
      fop(3, 8'h00);
      fop(2, 8'h00);
      cyc(2);
      chk(fuse_locked_o, 1'b1);
      fop(0, 8'h81);
      fop(3, 8'h00);
      chk(burn_refused_o, 1'b1);
      fop(2, 8'h00);
      rd(8'h80);
      $display("lock test done");
    end
  endtask
  // f is burned into set 0 first; lo is the expected ramp length,
  // zero means the host sets power keep only and skips the ramp
  task t_serial(input [7:0] f, input integer lo);
    begin
      rst;
      serial_mode_i = 1'b1;
      fop(0, f);
      fop(3, 8'h00);
      serial_start_i = 1'b1;
      cyc(1);
      serial_start_i = 1'b0;
      wait_for(0, 10);
      cyc(5);
      chk({seq_waiting_o, seq_done_o}, 2'h2);
      go = lo > 0 ? 2'h3 : 2'h1;
      wait_for(1, 120);
      chk(n >= lo && n <= lo + 8, 1'b1);
      monitor_bit_i = 1'b1;
      cyc(5);
      chk(mode_o, 2'h2);
      monitor_bit_i = 1'b0;
      reg_wr_i = 1'b1;
      cyc(1);
      reg_wr_i = 1'b0;
      wait_for(2, 5);
      go = 2'h0;
      serial_mode_i = 1'b0;
      $display("serial test done");
    end
  endtask
  task t_alone;
    begin
      rst;
      pin_lvl = 2'h1;
      wait_for(1, 120);
      chk(mode_o, 2'h1);
      fop(0, 8'h3c);
      cyc(2);
      chk(mic_gain_o, 8'h3c);
      reg_override_i = 1'b1;
      cyc(5);
      chk(mic_gain_o, override_gain_i);
      for (k = 0; k < 4; k = k + 1)
      begin
        duty_i = k[1:0];
        cyc(16);
        hi = 0;
        repeat (16) begin cyc(1); hi = hi + status_current_output_o; end
        chk(hi, k == 3 ? 16 : 4 * k);
      end
      supply_low_flag_i = 1'b1;
      cyc(100);
      hi = 0;
      repeat (100) begin cyc(1); hi = hi + status_current_output_o; end
      chk(hi >= 20 && hi <= 30, 1'b1);
      supply_low_flag_i = 1'b0;
      duty_i = 2'h0;
      pin_lvl = 2'h2;
      cyc(8);
      chk(mode_o, 2'h2);
      chk(mic_gain_o, monitor_gain_i);
      chk({hp_src_o, line_gain_o}, {monitor_src_i, monitor_line_gain_i});
      monitor_vol_follow_i = 1'b1;
      cyc(5);
      chk(mic_gain_o, {2'h0, volume_control_input_i});
      pin_lvl = 2'h0;
      wait_for(2, 10);
      chk(mode_o, 2'h0);
      $display("stand-alone test done");
    end
  endtask
  initial
  begin
    cyc(1);
    t_store;
    t_lock;
    t_serial(8'h00, 90);
    t_serial(8'h40, 60);
    t_serial(8'h00, 0);
    t_alone;
    final_report;
  end
endmodule // scotp_top_test
